// *** hw/sideband_defs.vh ***
`ifndef SIDEBAND_DEFS_VH
`define SIDEBAND_DEFS_VH

// clock rate and the timing figures, in their own units
`define CLK_FREQ_KHZ 250000
`define INIT_TIME_MS 2000
`define WAKE_TIME_MS 300

// register byte addresses
`define ADDR_FLAG 8'h00
`define ADDR_MASK 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_STATE 8'h0c

// flag and mask layout
`define FLAG_W 4
`define FLAG_INIT_DONE 0
`define FLAG_RX_LOSS 1
`define FLAG_TX_FAULT 2
`define FLAG_AUX 3

// control layout
`define CTRL_W 4
`define CTRL_OVERRIDE 0
`define CTRL_POWER_SET 1
`define CTRL_PIN_TRANSMIT_DISABLE_SELECT 2
`define CTRL_OUT_LOSS 3

// state register layout
`define ST_DATA_NOT_READY 0
`define ST_LOW_POWER 1
`define ST_OPERATIONAL 2
`define ST_SELECT_PIN 3
`define ST_SEQ_LSB 4

// reset values
`define FLAG_RST 4'h0
`define MASK_RST 4'h0
`define CTRL_RST 4'h0
`define SYNC_RST 5'h01

`endif

// *** hw/sideband_ctrl.v ***
`timescale 1ns/1ps
`include "sideband_defs.vh"

// Notes on behaviour
// - init finishes within 2000 ms of any reset
// - fully functional within 2 s of power-on
// - management bus answers within 2 s
// - data-not-ready cleared, interrupt raised after init
// - back to full operation after reset release
// - interrupt line low within 200 ms
// - flags clear on read, line releases
// - receive loss sets flag within 100 ms
// - other events set flags within 200 ms
// - setting mask stops line pull-down
// - clearing mask restores line pull-down
// - dual select input switches function quickly
// - dual output switches irq/loss quickly
// - low-power select high enters low power
// - low-power select low returns to operation
// - override or power-set bits force low power
module sideband_ctrl #(
    parameter [31:0] INIT_CYCLES = `INIT_TIME_MS * `CLK_FREQ_KHZ,
    parameter [31:0] WAKE_CYCLES = `WAKE_TIME_MS * `CLK_FREQ_KHZ
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // sideband pins from the host
    input wire module_reset_line_n_i,
    input wire low_power_select_i,
    // module conditions
    input wire rx_loss_i,
    input wire tx_fault_i,
    input wire aux_event_i,
    // open-drain dual output, interrupt or receive loss
    output reg module_irq_line_o,
    output reg module_irq_line_oe_o,
    // internal status
    output reg irq_o,
    output reg low_power_o,
    output reg tx_disable_o,
    output reg operational_o,
    output reg mgmt_bus_ready_o
);

    localparam [1:0] SEQ_HOLD = 2'b00;
    localparam [1:0] SEQ_INIT = 2'b01;
    localparam [1:0] SEQ_READY = 2'b10;

    // byte-lane write for a narrow register in lane 0
    function [3:0] lane_write;
        input [3:0] old_v;
        input [3:0] new_v;
        input sel_v;
        begin
            lane_write = sel_v ? new_v : old_v;
        end
    endfunction

    // rising edge of a synchronised pin; prev_reg resets to the idle level,
    // so no false event follows reset
    function rise_of;
        input now_v;
        input old_v;
        begin
            rise_of = now_v & ~old_v;
        end
    endfunction

    // pin synchronisers: bit 0 reset line, 1 select, 2 loss, 3 fault, 4 aux
    reg [4:0] meta_reg;
    reg [4:0] sync_reg;
    reg [4:0] prev_reg;

    reg [1:0] seq_reg;
    reg [1:0] seq_next;
    reg [31:0] init_cnt_reg;
    reg [31:0] init_cnt_next;
    reg [31:0] wake_cnt_reg;
    reg [31:0] wake_cnt_next;

    reg [3:0] flag_reg;
    reg [3:0] flag_next;
    reg [3:0] mask_reg;
    reg [3:0] mask_next;
    reg [3:0] ctrl_reg;
    reg [3:0] ctrl_next;

    reg [31:0] rdata_next;
    reg [3:0] flag_set;
    reg [3:0] flag_clr;

    wire reset_line_n;
    wire select_pin;
    wire loss_level;
    wire bus_access;
    wire rd_access;
    wire wr_access;
    wire init_done_pulse;
    wire soft_hold;
    wire low_power_req;
    wire irq_pending;
    wire hit_flag;
    wire hit_mask;
    wire hit_ctrl;
    wire hit_state;

    assign reset_line_n = sync_reg[0];
    assign select_pin = sync_reg[1];
    assign loss_level = sync_reg[2];

    assign bus_access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_access = bus_access & ~wb_we_i;
    assign wr_access = bus_access & wb_we_i;

    // one decode shared by the clear, write and read paths;
    // an unmapped address hits none of them and reads zero
    assign hit_flag = (wb_adr_i == `ADDR_FLAG);
    assign hit_mask = (wb_adr_i == `ADDR_MASK);
    assign hit_ctrl = (wb_adr_i == `ADDR_CTRL);
    assign hit_state = (wb_adr_i == `ADDR_STATE);

    assign soft_hold = (seq_reg == SEQ_HOLD);
    assign init_done_pulse = (seq_reg == SEQ_INIT) && reset_line_n &&
        (init_cnt_reg == INIT_CYCLES - 32'd1);

    // the select pin only asks for low power while it serves that function
    assign low_power_req = (~ctrl_reg[`CTRL_PIN_TRANSMIT_DISABLE_SELECT] & select_pin) |
        ctrl_reg[`CTRL_OVERRIDE] | ctrl_reg[`CTRL_POWER_SET];

    assign irq_pending = |(flag_reg & ~mask_reg);

    // two-flop synchronisers; logic reads sync_reg and prev_reg, never meta_reg
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= `SYNC_RST;
        end else begin
            meta_reg <= {aux_event_i, tx_fault_i, rx_loss_i,
                         low_power_select_i, module_reset_line_n_i};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg <= `SYNC_RST;
        end else begin
            sync_reg <= meta_reg;
        end
    end

    // previous synced value, for the event edge detectors
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= `SYNC_RST;
        end else begin
            prev_reg <= sync_reg;
        end
    end

    // start-up sequence
    always @* begin
        seq_next = seq_reg;
        init_cnt_next = init_cnt_reg;
        case (seq_reg)
            SEQ_HOLD: begin
                init_cnt_next = 32'd0;
                // any low pulse that survives the synchroniser restarts init
                if (reset_line_n) begin
                    seq_next = SEQ_INIT;
                end
            end
            SEQ_INIT: begin
                if (!reset_line_n) begin
                    seq_next = SEQ_HOLD;
                end else if (init_done_pulse) begin
                    seq_next = SEQ_READY;
                end else begin
                    init_cnt_next = init_cnt_reg + 32'd1;
                end
            end
            SEQ_READY: begin
                if (!reset_line_n) begin
                    seq_next = SEQ_HOLD;
                end
            end
            default: begin
                seq_next = SEQ_HOLD;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_reg <= SEQ_INIT;
            init_cnt_reg <= 32'd0;
        end else begin
            seq_reg <= seq_next;
            init_cnt_reg <= init_cnt_next;
        end
    end

    // settle time after leaving low power; it runs during init too,
    // so a module that starts in full power is ready once init ends
    always @* begin
        wake_cnt_next = wake_cnt_reg;
        if (low_power_req || soft_hold) begin
            wake_cnt_next = 32'd0;
        end else if (wake_cnt_reg < WAKE_CYCLES) begin
            wake_cnt_next = wake_cnt_reg + 32'd1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_cnt_reg <= 32'd0;
        end else begin
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // event flags: hardware set wins over a read or write-one clear
    always @* begin
        flag_set = 4'h0;
        flag_set[`FLAG_INIT_DONE] = init_done_pulse;
        if (seq_reg == SEQ_READY) begin
            flag_set[`FLAG_RX_LOSS] = rise_of(sync_reg[2], prev_reg[2]);
            flag_set[`FLAG_TX_FAULT] = rise_of(sync_reg[3], prev_reg[3]);
            flag_set[`FLAG_AUX] = rise_of(sync_reg[4], prev_reg[4]);
        end
        flag_clr = 4'h0;
        if (rd_access && hit_flag) begin
            flag_clr = flag_reg;
        end else if (wr_access && hit_flag && wb_sel_i[0]) begin
            flag_clr = wb_dat_i[3:0];
        end
        flag_next = (flag_reg & ~flag_clr) | flag_set;
        if (soft_hold) begin
            flag_next = `FLAG_RST;
        end
    end

    // software-written registers
    always @* begin
        mask_next = mask_reg;
        ctrl_next = ctrl_reg;
        if (soft_hold) begin
            mask_next = `MASK_RST;
            ctrl_next = `CTRL_RST;
        end else if (wr_access) begin
            if (hit_mask) begin
                mask_next = lane_write(mask_reg, wb_dat_i[3:0], wb_sel_i[0]);
            end else if (hit_ctrl) begin
                ctrl_next = lane_write(ctrl_reg, wb_dat_i[3:0], wb_sel_i[0]);
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= `FLAG_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // read data; unmapped addresses read zero and still acknowledge
    always @* begin
        rdata_next = 32'h0;
        if (hit_flag) begin
            rdata_next[3:0] = flag_reg;
        end else if (hit_mask) begin
            rdata_next[3:0] = mask_reg;
        end else if (hit_ctrl) begin
            rdata_next[3:0] = ctrl_reg;
        end else if (hit_state) begin
            rdata_next[`ST_DATA_NOT_READY] = (seq_reg != SEQ_READY);
            rdata_next[`ST_LOW_POWER] = low_power_o;
            rdata_next[`ST_OPERATIONAL] = operational_o;
            rdata_next[`ST_SELECT_PIN] = select_pin;
            rdata_next[`ST_SEQ_LSB + 1:`ST_SEQ_LSB] = seq_reg;
        end
    end

    // bus answers one cycle after the request, always, even during init
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_access;
        end
    end

    // data is zero outside the ack cycle, so a late sampler sees no stale flags
    always @(posedge clk_i) begin
        if (rst_i || !rd_access) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= rdata_next;
        end
    end

    // pin and status outputs, each one flop behind its cause
    // the pin only ever pulls low; the host pull-up makes it high
    always @(posedge clk_i) begin
        if (rst_i) begin
            module_irq_line_o <= 1'b0;
            module_irq_line_oe_o <= 1'b0;
        end else begin
            module_irq_line_o <= 1'b0;
            if (soft_hold) begin
                module_irq_line_oe_o <= 1'b0;
            end else if (ctrl_reg[`CTRL_OUT_LOSS]) begin
                // loss mode shows the live level: not masked, not latched
                module_irq_line_oe_o <= loss_level;
            end else begin
                module_irq_line_oe_o <= irq_pending;
            end
        end
    end

    // interrupt level as software sees it, whatever the pin mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_pending;
        end
    end

    // power state: reset and host hold both count as lowest power
    always @(posedge clk_i) begin
        if (rst_i) begin
            low_power_o <= 1'b1;
            tx_disable_o <= 1'b0;
        end else begin
            low_power_o <= low_power_req | soft_hold;
            tx_disable_o <= ctrl_reg[`CTRL_PIN_TRANSMIT_DISABLE_SELECT] & select_pin;
        end
    end

    // the bus is up once init ends; full function also waits for the settle count
    always @(posedge clk_i) begin
        if (rst_i) begin
            operational_o <= 1'b0;
            mgmt_bus_ready_o <= 1'b0;
        end else begin
            operational_o <= (seq_reg == SEQ_READY) && !low_power_req &&
                (wake_cnt_reg >= WAKE_CYCLES);
            mgmt_bus_ready_o <= (seq_reg == SEQ_READY);
        end
    end

endmodule // sideband_ctrl

// *** dv/sideband_ctrl_assertions.sv ***
`timescale 1ns/1ps
module sideband_ctrl_checker #(
    parameter [31:0] INIT_CYCLES = 32'h14
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus and host pins
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire module_reset_line_n_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // pin and status outputs
    input wire module_irq_line_o,
    input wire module_irq_line_oe_o,
    input wire irq_o,
    input wire low_power_o,
    input wire operational_o,
    input wire mgmt_bus_ready_o
);
    // cycles spent waiting for init; a host reset restarts the wait
    logic [31:0] wait_reg;
    always @(posedge clk_i) begin
        if (rst_i || mgmt_bus_ready_o || !module_reset_line_n_i) begin
            wait_reg <= 32'h0;
        end else begin
            wait_reg <= wait_reg + 32'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    reset_state_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o &&
        low_power_o && !operational_o && !mgmt_bus_ready_o && !irq_o && !module_irq_line_oe_o)
        else $error("outputs wrong after reset");
    init_time_a: assert property (wait_reg <= INIT_CYCLES + 32'h6)
        else $error("init took too long");
    init_irq_a: assert property ($rose(mgmt_bus_ready_o) |-> irq_o)
        else $error("no interrupt at init end");
    host_reset_a: assert property (!module_reset_line_n_i [*6] |->
        !mgmt_bus_ready_o && low_power_o && !module_irq_line_oe_o)
        else $error("host reset not honoured");
    oper_ready_a: assert property ($rose(operational_o) |-> mgmt_bus_ready_o)
        else $error("operational before bus ready");
    drain_only_a: assert property (module_irq_line_oe_o |-> !module_irq_line_o)
        else $error("line driven high");
    lp_entry_a: assert property ($rose(low_power_o) |-> ##[0:2] !operational_o)
        else $error("operational in low power");
    cover property ($rose(irq_o));
    cover property ($rose(low_power_o) ##[1:400] $rose(operational_o));
    cover property ($fell(module_reset_line_n_i));
endmodule // sideband_ctrl_checker

bind sideband_ctrl sideband_ctrl_checker #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .module_reset_line_n_i, .wb_dat_o, .wb_ack_o, .module_irq_line_o,
    .module_irq_line_oe_o, .irq_o, .low_power_o, .operational_o, .mgmt_bus_ready_o);

// *** dv/host_pins_model.sv ***
`timescale 1ns/1ps
module host_pins_model (
    // clock
    input wire clk_i,
    // sideband pins toward the module
    output logic module_reset_line_n_o,
    output logic low_power_select_o
);
    initial begin
        module_reset_line_n_o = 1'b1;
        low_power_select_o = 1'b0;
    end
    // the caller picks the low time; 2500 cycles is 10 us at 250 MHz
    task pulse_reset(input int cycles);
        @(posedge clk_i);
        module_reset_line_n_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        module_reset_line_n_o <= 1'b1;
    endtask
    task set_low_power(input logic val);
        @(posedge clk_i);
        low_power_select_o <= val;
    endtask
endmodule // host_pins_model

// *** dv/sideband_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module sideband_ctrl_tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic rxl = 1'b0, txf = 1'b0, aux = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, rst_n, lp, od, oe, irq, lpo, txd, opr, rdy;
    logic [3:0] m;
    logic [31:0] exp_q[$];
    int num_errors = 0, num_checks = 0, seed = 28873, r;
    always #2 clk_i = ~clk_i;
    host_pins_model host_u (.clk_i(clk_i), .module_reset_line_n_o(rst_n),
        .low_power_select_o(lp));
    sideband_ctrl #(.INIT_CYCLES(32'h14), .WAKE_CYCLES(32'ha)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .module_reset_line_n_i(rst_n), .low_power_select_i(lp), .rx_loss_i(rxl),
        .tx_fault_i(txf), .aux_event_i(aux), .module_irq_line_o(od),
        .module_irq_line_oe_o(oe), .irq_o(irq), .low_power_o(lpo), .tx_disable_o(txd),
        .operational_o(opr), .mgmt_bus_ready_o(rdy));
    task check(input string name, input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, want, seen);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task bail(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            wrap_up;
        end
    endtask
    // for reads d is the expected word
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        bail(n, 40);
        cyc <= 1'b0;
    endtask
    task wait_up;
        int n;
        n = 0;
        while ((rdy & opr) !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        bail(n, 200);
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            check("read data", rdat, exp_q.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_up;
        check("irq", irq, 1'b1);
        bus(0, 8'h0c, 32'h24);
        bus(0, 8'h00, 32'h1);
        repeat (3) @(posedge clk_i);
        check("irq", irq, 1'b0);
        r = $random(seed);
        m = r[3:0];
        bus(1, 8'h04, {28'h0, m});
        rxl <= 1'b1;
        txf <= 1'b1;
        aux <= 1'b1;
        repeat (6) @(posedge clk_i);
        check("irq", irq, |(~m & 4'he));
        check("line", oe, |(~m & 4'he));
        check("line value", od, 1'b0);
        bus(0, 8'h00, 32'he);
        repeat (3) @(posedge clk_i);
        check("irq", irq, 1'b0);
        rxl <= 1'b0;
        txf <= 1'b0;
        aux <= 1'b0;
        bus(1, 8'h04, 32'hf);
        rxl <= 1'b1;
        repeat (6) @(posedge clk_i);
        check("irq", irq, 1'b0);
        bus(1, 8'h04, 32'h0);
        repeat (3) @(posedge clk_i);
        check("irq", irq, 1'b1);
        bus(0, 8'h00, 32'h2);
        rxl <= 1'b0;
        bus(1, 8'h08, 32'h8);
        bus(0, 8'h08, 32'h8);
        rxl <= 1'b1;
        repeat (6) @(posedge clk_i);
        check("loss line", oe, 1'b1);
        rxl <= 1'b0;
        repeat (6) @(posedge clk_i);
        check("loss line", oe, 1'b0);
        bus(1, 8'h08, 32'h0);
        bus(0, 8'h00, 32'h2);
        host_u.set_low_power(1'b1);
        repeat (6) @(posedge clk_i);
        check("low power", lpo, 1'b1);
        host_u.set_low_power(1'b0);
        wait_up;
        check("low power", lpo, 1'b0);
        for (int i = 0; i < 2; i++) begin
            bus(1, 8'h08, 32'h1 << i);
            repeat (3) @(posedge clk_i);
            check("low power", lpo, 1'b1);
            bus(1, 8'h08, 32'h0);
            wait_up;
        end
        bus(1, 8'h08, 32'h4);
        host_u.set_low_power(1'b1);
        repeat (6) @(posedge clk_i);
        check("tx disable", txd, 1'b1);
        check("low power", lpo, 1'b0);
        host_u.set_low_power(1'b0);
        bus(1, 8'h08, 32'h0);
        sel <= 4'he;
        bus(1, 8'h04, 32'hf);
        sel <= 4'hf;
        bus(0, 8'h04, 32'h0);
        bus(1, 8'h10, 32'hf);
        bus(1, 8'h0c, 32'hf);
        bus(0, 8'h10, 32'h0);
        bus(0, 8'h0c, 32'h24);
        host_u.pulse_reset(2500);
        repeat (4) @(posedge clk_i);
        check("ready", rdy, 1'b0);
        wait_up;
        bus(0, 8'h00, 32'h1);
        wrap_up;
    end
endmodule // sideband_ctrl_tb_top
